// ===== verilog/csf_flags.sv
// status flag generation and storage with avalon-mm register access
//
// Operation
// - sign7 zero6 half4 pv2 sub1 carry0 layout
// - two flag registers, bits 3,5 unused
// - conditions test only carry, pv, zero, sign
// - carry on add carry, sub borrow
// - decimal adjust sets carry when correcting the upper digit
// - shifts leave shifted-out bit in carry
// - and, or, xor clear carry
// - set carry forces, invert carry toggles
// - add clears subtract, sub sets it
// - add overflow on same-sign wrong result
// - sub overflow only for unlike signs
// - overflow is carry7 in xor out
// - logic, shift and circular rotate pv is even parity
// - block search and move pv clear when count zero
// - vector/refresh loads copy interrupt enable
// - port input sets parity, zero, sign
// - half carry from bit 3 or 4
// - zero flag when result byte zero
// - compare zero when accumulator equals memory
// - bit test zero is inverted bit
// - block io zero when b reaches zero
// - sign is result bit 7
//
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module csf_flags (
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        srst_in,
    // operation request
    input  wire logic        op_valid_in,
    input  wire logic [4:0]  op_code_in,
    input  wire logic [7:0]  opa_in,
    input  wire logic [7:0]  opb_in,
    input  wire logic [2:0]  bit_sel_in,
    input  wire logic        count_zero_in,
    input  wire logic        interrupt_enable_copy_in,
    // operation result
    output logic      [7:0]  result_out,
    // branch condition test
    input  wire logic [2:0]  cond_sel_in,
    output logic             cond_true_out,
    // flag values
    output logic      [7:0]  flags_main_out,
    output logic      [7:0]  flags_alt_out,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out
);
    typedef struct packed {
        logic [7:0]          flags_main;
        logic [7:0]          flags_alt;
        logic [7:0]          result;
        logic [31:0]         rdata;
        logic                last_cond;
        csf_pkg::csf_bus_st_t bus_st;
    } csf_state_t;

    csf_state_t state_r;
    csf_state_t state_nxt;

    csf_pkg::csf_op_t op;
    logic [7:0] add_sum;
    logic       add_c;
    logic       add_h;
    logic       add_v;
    logic       add_sub;
    logic       add_cin;
    logic [7:0] add_b;
    logic [7:0] sh_data;
    logic       sh_c;
    logic [2:0] sh_kind;
    logic [7:0] f;
    logic [7:0] res;
    logic [7:0] daa_corr;
    logic       daa_c;
    logic       bus_hit;
    logic [31:0] rd_word;

    assign op = csf_pkg::csf_op_t'(op_code_in);

    always_comb begin
        add_b   = opb_in;
        add_cin = 1'b0;
        add_sub = 1'b0;
        case (op)
            csf_pkg::OP_ADC: add_cin = state_r.flags_main[csf_pkg::FLAG_CARRY_POS];
            csf_pkg::OP_SUB: add_sub = 1'b1;
            csf_pkg::OP_CMP: add_sub = 1'b1;
            csf_pkg::OP_BLOCK_SEARCH: add_sub = 1'b1;
            csf_pkg::OP_SBC: begin
                add_sub = 1'b1;
                add_cin = state_r.flags_main[csf_pkg::FLAG_CARRY_POS];
            end
            csf_pkg::OP_DECIMAL_ADJ: begin
                add_b   = daa_corr;
                add_sub = state_r.flags_main[csf_pkg::FLAG_SUB_POS];
            end
            default: add_b = opb_in;
        endcase
    end

    always_comb begin
        case (op)
            csf_pkg::OP_ROT_LEFT_ACC:   sh_kind = 3'h0;
            csf_pkg::OP_ROT_LEFT_CIRC:  sh_kind = 3'h0;
            csf_pkg::OP_SHIFT_LEFT_AR:  sh_kind = 3'h1;
            csf_pkg::OP_ROT_RIGHT_ACC:  sh_kind = 3'h2;
            csf_pkg::OP_ROT_RIGHT_CIRC: sh_kind = 3'h2;
            csf_pkg::OP_SHIFT_RIGHT_AR: sh_kind = 3'h3;
            csf_pkg::OP_SHIFT_RIGHT_LG: sh_kind = 3'h4;
            default:                    sh_kind = 3'h7;
        endcase
    end

    // decimal correction from accumulator and flags
    always_comb begin
        daa_corr = 8'h00;
        daa_c    = state_r.flags_main[csf_pkg::FLAG_CARRY_POS];
        if (state_r.flags_main[csf_pkg::FLAG_HALF_POS] || (opa_in[3:0] > 4'h9)) begin
            daa_corr[3:0] = 4'h6;
        end
        if (state_r.flags_main[csf_pkg::FLAG_CARRY_POS] || (opa_in > 8'h99)) begin
            daa_corr[7:4] = 4'h6;
            daa_c = 1'b1;
        end
    end

    csf_adder u_adder (
        .a_in      (opa_in),
        .b_in      (add_b),
        .cin_in    (add_cin),
        .sub_in    (add_sub),
        .sum_out   (add_sum),
        .carry_out (add_c),
        .half_out  (add_h),
        .ovf_out   (add_v)
    );

    csf_shifter u_shifter (
        .data_in   (opa_in),
        .cin_in    (state_r.flags_main[csf_pkg::FLAG_CARRY_POS]),
        .kind_in   (sh_kind),
        .data_out  (sh_data),
        .carry_out (sh_c)
    );

    // flag update
    always_comb begin
        f   = state_r.flags_main;
        res = state_r.result;
        if (op_valid_in) begin
            case (op)
                csf_pkg::OP_ADD, csf_pkg::OP_ADC, csf_pkg::OP_SUB, csf_pkg::OP_SBC, csf_pkg::OP_CMP: begin
                    res = (op == csf_pkg::OP_CMP) ? opa_in : add_sum;
                    f[csf_pkg::FLAG_SIGN_POS]  = add_sum[7];
                    f[csf_pkg::FLAG_ZERO_POS]  = (add_sum == 8'h00);
                    f[csf_pkg::FLAG_HALF_POS]  = add_h;
                    f[csf_pkg::FLAG_PV_POS]    = add_v;
                    f[csf_pkg::FLAG_SUB_POS]   = add_sub;
                    f[csf_pkg::FLAG_CARRY_POS] = add_c;
                end
                csf_pkg::OP_AND, csf_pkg::OP_OR, csf_pkg::OP_XOR: begin
                    res = (op == csf_pkg::OP_AND) ? (opa_in & opb_in) :
                          (op == csf_pkg::OP_OR)  ? (opa_in | opb_in) : (opa_in ^ opb_in);
                    f[csf_pkg::FLAG_SIGN_POS]  = res[7];
                    f[csf_pkg::FLAG_ZERO_POS]  = (res == 8'h00);
                    f[csf_pkg::FLAG_HALF_POS]  = (op == csf_pkg::OP_AND);
                    f[csf_pkg::FLAG_PV_POS]    = ~(^res);
                    f[csf_pkg::FLAG_SUB_POS]   = 1'b0;
                    f[csf_pkg::FLAG_CARRY_POS] = 1'b0;
                end
                csf_pkg::OP_DECIMAL_ADJ: begin
                    res = add_sum;
                    f[csf_pkg::FLAG_SIGN_POS]  = add_sum[7];
                    f[csf_pkg::FLAG_ZERO_POS]  = (add_sum == 8'h00);
                    f[csf_pkg::FLAG_HALF_POS]  = add_h;
                    f[csf_pkg::FLAG_PV_POS]    = ~(^add_sum);
                    f[csf_pkg::FLAG_CARRY_POS] = daa_c;
                end
                csf_pkg::OP_ROT_LEFT_ACC, csf_pkg::OP_ROT_RIGHT_ACC: begin
                    res = sh_data;
                    f[csf_pkg::FLAG_HALF_POS]  = 1'b0;
                    f[csf_pkg::FLAG_SUB_POS]   = 1'b0;
                    f[csf_pkg::FLAG_CARRY_POS] = sh_c;
                end
                csf_pkg::OP_ROT_LEFT_CIRC, csf_pkg::OP_SHIFT_LEFT_AR, csf_pkg::OP_ROT_RIGHT_CIRC,
                csf_pkg::OP_SHIFT_RIGHT_AR, csf_pkg::OP_SHIFT_RIGHT_LG: begin
                    res = sh_data;
                    f[csf_pkg::FLAG_SIGN_POS]  = sh_data[7];
                    f[csf_pkg::FLAG_ZERO_POS]  = (sh_data == 8'h00);
                    f[csf_pkg::FLAG_HALF_POS]  = 1'b0;
                    f[csf_pkg::FLAG_PV_POS]    = ~(^sh_data);
                    f[csf_pkg::FLAG_SUB_POS]   = 1'b0;
                    f[csf_pkg::FLAG_CARRY_POS] = sh_c;
                end
                csf_pkg::OP_SET_CARRY: begin
                    f[csf_pkg::FLAG_HALF_POS]  = 1'b0;
                    f[csf_pkg::FLAG_SUB_POS]   = 1'b0;
                    f[csf_pkg::FLAG_CARRY_POS] = 1'b1;
                end
                csf_pkg::OP_INVERT_CARRY: begin
                    f[csf_pkg::FLAG_HALF_POS]  = state_r.flags_main[csf_pkg::FLAG_CARRY_POS];
                    f[csf_pkg::FLAG_SUB_POS]   = 1'b0;
                    f[csf_pkg::FLAG_CARRY_POS] = ~state_r.flags_main[csf_pkg::FLAG_CARRY_POS];
                end
                csf_pkg::OP_BLOCK_SEARCH: begin
                    f[csf_pkg::FLAG_SIGN_POS]  = add_sum[7];
                    f[csf_pkg::FLAG_ZERO_POS]  = (opa_in == opb_in);
                    f[csf_pkg::FLAG_HALF_POS]  = add_h;
                    f[csf_pkg::FLAG_PV_POS]    = ~count_zero_in;
                    f[csf_pkg::FLAG_SUB_POS]   = 1'b1;
                end
                csf_pkg::OP_BLOCK_MOVE: begin
                    f[csf_pkg::FLAG_HALF_POS]  = 1'b0;
                    f[csf_pkg::FLAG_PV_POS]    = ~count_zero_in;
                    f[csf_pkg::FLAG_SUB_POS]   = 1'b0;
                end
                csf_pkg::OP_BLOCK_IO_STEP: begin
                    f[csf_pkg::FLAG_ZERO_POS]  = count_zero_in;
                    f[csf_pkg::FLAG_SUB_POS]   = 1'b1;
                end
                csf_pkg::OP_LOAD_VEC_REF: begin
                    res = opa_in;
                    f[csf_pkg::FLAG_SIGN_POS]  = opa_in[7];
                    f[csf_pkg::FLAG_ZERO_POS]  = (opa_in == 8'h00);
                    f[csf_pkg::FLAG_HALF_POS]  = 1'b0;
                    f[csf_pkg::FLAG_PV_POS]    = interrupt_enable_copy_in;
                    f[csf_pkg::FLAG_SUB_POS]   = 1'b0;
                end
                csf_pkg::OP_INPUT_PORT_C: begin
                    res = opa_in;
                    f[csf_pkg::FLAG_SIGN_POS]  = opa_in[7];
                    f[csf_pkg::FLAG_ZERO_POS]  = (opa_in == 8'h00);
                    f[csf_pkg::FLAG_HALF_POS]  = 1'b0;
                    f[csf_pkg::FLAG_PV_POS]    = ~(^opa_in);
                    f[csf_pkg::FLAG_SUB_POS]   = 1'b0;
                end
                csf_pkg::OP_BIT_TEST: begin
                    f[csf_pkg::FLAG_ZERO_POS]  = ~opa_in[bit_sel_in];
                    f[csf_pkg::FLAG_HALF_POS]  = 1'b1;
                    f[csf_pkg::FLAG_SUB_POS]   = 1'b0;
                end
                default: f = state_r.flags_main;
            endcase
        end
    end

    // only carry, pv, zero, sign are testable
    always_comb begin
        case (csf_pkg::csf_cond_t'(cond_sel_in))
            csf_pkg::COND_NZ: cond_true_out = ~state_r.flags_main[csf_pkg::FLAG_ZERO_POS];
            csf_pkg::COND_Z:  cond_true_out =  state_r.flags_main[csf_pkg::FLAG_ZERO_POS];
            csf_pkg::COND_NC: cond_true_out = ~state_r.flags_main[csf_pkg::FLAG_CARRY_POS];
            csf_pkg::COND_C:  cond_true_out =  state_r.flags_main[csf_pkg::FLAG_CARRY_POS];
            csf_pkg::COND_PO: cond_true_out = ~state_r.flags_main[csf_pkg::FLAG_PV_POS];
            csf_pkg::COND_PE: cond_true_out =  state_r.flags_main[csf_pkg::FLAG_PV_POS];
            csf_pkg::COND_P:  cond_true_out = ~state_r.flags_main[csf_pkg::FLAG_SIGN_POS];
            csf_pkg::COND_M:  cond_true_out =  state_r.flags_main[csf_pkg::FLAG_SIGN_POS];
            default:          cond_true_out = 1'b0;
        endcase
    end

    always_comb begin
        bus_hit = (avs_read_in || avs_write_in) && (state_r.bus_st == csf_pkg::BUS_IDLE);
        case (avs_address_in)
            csf_pkg::OFS_FLAGS_MAIN: rd_word = {24'h000000, state_r.flags_main};
            csf_pkg::OFS_FLAGS_ALT:  rd_word = {24'h000000, state_r.flags_alt};
            csf_pkg::OFS_LAST_COND:  rd_word = {31'h00000000, state_r.last_cond};
            default:                 rd_word = 32'h00000000;
        endcase
    end

    // next state
    always_comb begin
        state_nxt            = state_r;
        state_nxt.result     = res;
        state_nxt.last_cond  = cond_true_out;
        state_nxt.flags_main = f & csf_pkg::FLAG_DEFINED_MASK;
        if (op_valid_in && (op == csf_pkg::OP_EXCHANGE)) begin
            state_nxt.flags_main = state_r.flags_alt;
            state_nxt.flags_alt  = state_r.flags_main;
        end else if (avs_write_in && (state_r.bus_st == csf_pkg::BUS_DONE) && avs_byteenable_in[0]) begin
            if (avs_address_in == csf_pkg::OFS_FLAGS_MAIN) begin
                state_nxt.flags_main = avs_writedata_in[7:0] & csf_pkg::FLAG_DEFINED_MASK;
            end else if (avs_address_in == csf_pkg::OFS_FLAGS_ALT) begin
                state_nxt.flags_alt = avs_writedata_in[7:0] & csf_pkg::FLAG_DEFINED_MASK;
            end
        end
        case (state_r.bus_st)
            csf_pkg::BUS_IDLE: begin
                if (bus_hit) begin
                    state_nxt.rdata  = avs_read_in ? rd_word : 32'h00000000;
                    state_nxt.bus_st = csf_pkg::BUS_DONE;
                end
            end
            csf_pkg::BUS_DONE: state_nxt.bus_st = csf_pkg::BUS_IDLE;
            default:           state_nxt.bus_st = csf_pkg::BUS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            state_r.flags_main <= csf_pkg::FLAGS_MAIN_RST;
            state_r.flags_alt  <= csf_pkg::FLAGS_ALT_RST;
            state_r.result     <= 8'h00;
            state_r.rdata      <= 32'h00000000;
            state_r.last_cond  <= 1'b0;
            state_r.bus_st     <= csf_pkg::BUS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign flags_main_out      = state_r.flags_main;
    assign flags_alt_out       = state_r.flags_alt;
    assign result_out          = state_r.result;
    assign avs_readdata_out    = state_r.rdata;
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && (state_r.bus_st != csf_pkg::BUS_DONE);
endmodule

// ===== include/csf_pkg.sv
// package of constants and types for the status flag block
package csf_pkg;
    // flag bit positions
    localparam int FLAG_SIGN_POS   = 7;
    localparam int FLAG_ZERO_POS   = 6;
    localparam int FLAG_HALF_POS   = 4;
    localparam int FLAG_PV_POS     = 2;
    localparam int FLAG_SUB_POS    = 1;
    localparam int FLAG_CARRY_POS  = 0;
    localparam int FLAG_UNUSED3_POS = 3;
    localparam int FLAG_UNUSED5_POS = 5;
    // reset values
    localparam logic [7:0] FLAGS_MAIN_RST = 8'h00;
    localparam logic [7:0] FLAGS_ALT_RST  = 8'h00;
    localparam logic [7:0] FLAG_DEFINED_MASK = 8'hd7;
    // avalon register offsets (byte addresses)
    localparam logic [3:0] OFS_FLAGS_MAIN = 4'h0;
    localparam logic [3:0] OFS_FLAGS_ALT  = 4'h4;
    localparam logic [3:0] OFS_LAST_COND  = 4'h8;
    // bus latency
    localparam int BUS_WAIT_CYCLES = 1;

    // flag-affecting operations
    typedef enum logic [4:0] {
        OP_NONE          = 5'h00,
        OP_ADD           = 5'h01,
        OP_ADC           = 5'h02,
        OP_SUB           = 5'h03,
        OP_SBC           = 5'h04,
        OP_CMP           = 5'h05,
        OP_AND           = 5'h06,
        OP_OR            = 5'h07,
        OP_XOR           = 5'h08,
        OP_DECIMAL_ADJ   = 5'h09,
        OP_ROT_LEFT_ACC  = 5'h0a,
        OP_ROT_LEFT_CIRC = 5'h0b,
        OP_SHIFT_LEFT_AR = 5'h0c,
        OP_ROT_RIGHT_ACC = 5'h0d,
        OP_ROT_RIGHT_CIRC = 5'h0e,
        OP_SHIFT_RIGHT_AR = 5'h0f,
        OP_SHIFT_RIGHT_LG = 5'h10,
        OP_SET_CARRY     = 5'h11,
        OP_INVERT_CARRY  = 5'h12,
        OP_BLOCK_SEARCH  = 5'h13,
        OP_BLOCK_MOVE    = 5'h14,
        OP_BLOCK_IO_STEP = 5'h15,
        OP_LOAD_VEC_REF  = 5'h16,
        OP_INPUT_PORT_C  = 5'h17,
        OP_BIT_TEST      = 5'h18,
        OP_EXCHANGE      = 5'h19
    } csf_op_t;

    // branch condition codes: only carry, pv, zero, sign are testable
    typedef enum logic [2:0] {
        COND_NZ = 3'h0,
        COND_Z  = 3'h1,
        COND_NC = 3'h2,
        COND_C  = 3'h3,
        COND_PO = 3'h4,
        COND_PE = 3'h5,
        COND_P  = 3'h6,
        COND_M  = 3'h7
    } csf_cond_t;

    // bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } csf_bus_st_t;
endpackage

// ===== verilog/csf_adder.sv
// 8-bit adder/subtractor with carry, half-carry and overflow
`timescale 1ns/1ps
module csf_adder (
    // operands
    input  wire logic [7:0] a_in,
    input  wire logic [7:0] b_in,
    input  wire logic       cin_in,
    input  wire logic       sub_in,
    // results
    output logic      [7:0] sum_out,
    output logic            carry_out,
    output logic            half_out,
    output logic            ovf_out
);
    logic [7:0] b_eff;
    logic [4:0] lo;
    logic [3:0] mid;
    logic [1:0] hi;
    logic       c_in7;
    logic       c_out7;

    always_comb begin
        b_eff = sub_in ? ~b_in : b_in;
        lo    = {1'b0, a_in[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_in ^ sub_in};
        mid   = {1'b0, a_in[6:4]} + {1'b0, b_eff[6:4]} + {3'h0, lo[4]};
        c_in7 = mid[3];
        hi    = {1'b0, a_in[7]} + {1'b0, b_eff[7]} + {1'b0, c_in7};
        c_out7 = hi[1];
        sum_out = {hi[0], mid[2:0], lo[3:0]};
        carry_out = c_out7 ^ sub_in;
        half_out = lo[4] ^ sub_in;
        ovf_out = c_in7 ^ c_out7;
    end
endmodule

// ===== verilog/csf_shifter.sv
// rotate and shift unit returning result and carry
`timescale 1ns/1ps
module csf_shifter (
    // inputs
    input  wire logic [7:0] data_in,
    input  wire logic       cin_in,
    input  wire logic [2:0] kind_in,
    // outputs
    output logic      [7:0] data_out,
    output logic            carry_out
);
    always_comb begin
        data_out  = data_in;
        carry_out = cin_in;
        // carry takes the bit shifted out
        case (kind_in)
            3'h0: begin
                data_out  = {data_in[6:0], data_in[7]};
                carry_out = data_in[7];
            end
            3'h1: begin
                data_out  = {data_in[6:0], 1'b0};
                carry_out = data_in[7];
            end
            3'h2: begin
                data_out  = {data_in[0], data_in[7:1]};
                carry_out = data_in[0];
            end
            3'h3: begin
                data_out  = {data_in[7], data_in[7:1]};
                carry_out = data_in[0];
            end
            3'h4: begin
                data_out  = {1'b0, data_in[7:1]};
                carry_out = data_in[0];
            end
            default: begin
                data_out  = data_in;
                carry_out = cin_in;
            end
        endcase
    end
endmodule

// ===== dv/csf_flags_assertions.sv
// flag block port checks
`timescale 1ns/1ps
module csf_flags_assertions (
    input wire logic        sys_clk_in,
    input wire logic        srst_in,
    input wire logic        op_valid_in,
    input wire logic [4:0]  op_code_in,
    input wire logic [7:0]  opa_in,
    input wire logic [7:0]  opb_in,
    input wire logic [2:0]  bit_sel_in,
    input wire logic        count_zero_in,
    input wire logic        interrupt_enable_copy_in,
    input wire logic [7:0]  result_out,
    input wire logic [2:0]  cond_sel_in,
    input wire logic        cond_true_out,
    input wire logic [7:0]  flags_main_out,
    input wire logic [7:0]  flags_alt_out,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic        avs_waitrequest_out
);
    logic       go;
    logic       cflag;
    logic       tbit;
    logic [7:0] fm;
    assign go = op_valid_in && !avs_write_in;
    assign fm = flags_main_out;
    assign tbit = opa_in[bit_sel_in];
    assign cflag = cond_sel_in[2] ? (cond_sel_in[1] ? fm[7] : fm[2]) : (cond_sel_in[1] ? fm[0] : fm[6]);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    a_unused_bits_zero: assert property (fm[3] == 1'b0 && fm[5] == 1'b0)
        else $error("unused flag bit set");
    a_cond_select: assert property (cond_true_out == (cflag == cond_sel_in[0]))
        else $error("branch condition wrong");
    a_add_clears_sub: assert property (go && op_code_in == csf_pkg::OP_ADD |=> !fm[1])
        else $error("add left subtract flag set");
    a_sub_sets_sub: assert property (go && op_code_in == csf_pkg::OP_SUB
        |=> fm[1] && fm[0] == ($past(opa_in) < $past(opb_in))) else $error("sub flags wrong");
    a_logic_carry_clr: assert property (go && op_code_in inside {csf_pkg::OP_AND, csf_pkg::OP_OR,
        csf_pkg::OP_XOR} |=> !fm[0] && fm[2] == ~^result_out) else $error("logic flags wrong");
    a_zero_sign_res: assert property (go && op_code_in inside {csf_pkg::OP_ADD, csf_pkg::OP_SUB,
        csf_pkg::OP_AND} |=> fm[6] == (result_out == 8'h00) && fm[7] == result_out[7])
        else $error("zero or sign wrong");
    a_carry_set: assert property (go && op_code_in == csf_pkg::OP_SET_CARRY |=> fm[0])
        else $error("carry not set");
    a_carry_invert: assert property (go && op_code_in == csf_pkg::OP_INVERT_CARRY
        |=> fm[0] != $past(fm[0])) else $error("carry not inverted");
    a_block_count_pv: assert property (go && op_code_in inside {csf_pkg::OP_BLOCK_SEARCH,
        csf_pkg::OP_BLOCK_MOVE} |=> fm[2] == !$past(count_zero_in)) else $error("block pv wrong");
    a_vecref_pv: assert property (go && op_code_in == csf_pkg::OP_LOAD_VEC_REF
        |=> fm[2] == $past(interrupt_enable_copy_in)) else $error("pv not copied");
    a_bit_test_zero: assert property (go && op_code_in == csf_pkg::OP_BIT_TEST
        |=> fm[6] == !$past(tbit)) else $error("bit test zero wrong");
    a_alt_holds: assert property (!avs_write_in && !(op_valid_in && op_code_in == csf_pkg::OP_EXCHANGE)
        |=> $stable(flags_alt_out)) else $error("alt changed");
    c_add: cover property (go && op_code_in == csf_pkg::OP_ADD);
    c_exchange: cover property (go && op_code_in == csf_pkg::OP_EXCHANGE);
    c_bus_read: cover property (avs_read_in && !avs_waitrequest_out);
endmodule

// ===== dv/tb_cpu_status_flag_logic.sv
// flag block bench
`timescale 1ns/1ps
module tb_cpu_status_flag_logic;
    logic        sys_clk_in, srst_in, op_valid_in, count_zero_in, interrupt_enable_copy_in;
    logic [4:0]  op_code_in;
    logic [7:0]  opa_in, opb_in, result_out, flags_main_out, flags_alt_out;
    logic [2:0]  bit_sel_in, cond_sel_in;
    logic        cond_true_out, avs_read_in, avs_write_in, avs_waitrequest_out;
    logic [3:0]  avs_address_in, avs_byteenable_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, d;
    int          mismatches, n_checks, cyc;
    csf_flags DUT (.*);
    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end
    task automatic tally_and_finish();
        $display("checks %0d fails %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [7:0] af(input logic s, input logic [7:0] a, input logic [7:0] b);
        logic [8:0] r;
        logic       h;
        r = s ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
        h = s ? (a[3:0] < b[3:0]) : (({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'd15);
        return {r[7], r[7:0] == 8'h00, 1'b0, h, 1'b0, ((a[7] ^ b[7]) == s) && (r[7] != a[7]), s, r[8]};
    endfunction
    task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge sys_clk_in);
        {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} <= {!wr, wr, adr, wd};
        do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out;
        {avs_read_in, avs_write_in} <= 2'b00;
    endtask
    task automatic sp(input csf_pkg::csf_op_t c, input logic [7:0] a, b, input logic [2:0] x, input logic [7:0] m, e);
        @(posedge sys_clk_in);
        {op_valid_in, op_code_in, opa_in, opb_in, bit_sel_in, count_zero_in, interrupt_enable_copy_in} <=
            {1'b1, c, a, b, x, x[0], x[0]};
        @(posedge sys_clk_in);
        op_valid_in <= 1'b0;
        @(negedge sys_clk_in);
        chk(c.name(), flags_main_out & m, e);
    endtask
    task automatic t_arith();
        logic [7:0] a[5] = '{8'h78, 8'h7f, 8'hff, 8'h00, 8'h80};
        logic [7:0] b[5] = '{8'h69, 8'hc0, 8'h01, 8'h01, 8'h80};
        logic [4:0] s = 5'b01010;
        for (int i = 0; i < 5; i++) begin
            sp(s[i] ? csf_pkg::OP_SUB : csf_pkg::OP_ADD, a[i], b[i], 3'h0, 8'hff, af(s[i], a[i], b[i]));
        end
        sp(csf_pkg::OP_ADD, 8'h99, 8'h01, 3'h0, 8'h01, 8'h00);
        sp(csf_pkg::OP_DECIMAL_ADJ, 8'h9a, 8'h00, 3'h0, 8'h01, 8'h01);
    endtask
    task automatic t_logic();
        csf_pkg::csf_op_t c[3] = '{csf_pkg::OP_AND, csf_pkg::OP_OR, csf_pkg::OP_XOR};
        logic [7:0] a[3] = '{8'h07, 8'h00, 8'h80};
        logic [7:0] b[3] = '{8'hff, 8'h00, 8'h01};
        logic [7:0] r;
        for (int i = 0; i < 3; i++) begin
            r = (i == 0) ? a[i] & b[i] : (i == 1) ? a[i] | b[i] : a[i] ^ b[i];
            sp(csf_pkg::OP_SET_CARRY, 8'h00, 8'h00, 3'h0, 8'h01, 8'h01);
            sp(c[i], a[i], b[i], 3'h0, 8'hc5, {r[7], r == 8'h00, 3'h0, ~^r, 2'h0});
        end
        sp(csf_pkg::OP_INVERT_CARRY, 8'h00, 8'h00, 3'h0, 8'h01, 8'h01);
    endtask
    task automatic sh(input csf_pkg::csf_op_t c, input logic [7:0] a, r, input logic cy);
        sp(c, a, 8'h00, 3'h0, 8'h01, {7'h0, cy});
        chk("shift result", result_out, r);
    endtask
    task automatic t_bus();
        bus(1'b1, csf_pkg::OFS_FLAGS_MAIN, 32'h0000_00ff, d);
        bus(1'b0, csf_pkg::OFS_FLAGS_MAIN, 32'h0, d);
        chk("main readback", d[7:0], 8'hd7);
        bus(1'b1, csf_pkg::OFS_FLAGS_ALT, 32'h0000_005a, d);
        sp(csf_pkg::OP_ADD, 8'h01, 8'h01, 3'h0, 8'h00, 8'h00);
        chk("alt after op", flags_alt_out, 8'h52);
        sp(csf_pkg::OP_EXCHANGE, 8'h00, 8'h00, 3'h0, 8'hff, 8'h52);
        chk("alt after swap", flags_alt_out, 8'h00);
        bus(1'b1, 4'hc, 32'h0000_00ff, d);
        bus(1'b0, 4'hc, 32'h0, d);
        chk("unmapped read", d[7:0], 8'h00);
        bus(1'b0, csf_pkg::OFS_FLAGS_MAIN, 32'h0, d);
        chk("main kept", d[7:0], 8'h52);
    endtask
    task automatic t_cond();
        logic [7:0] v[2] = '{8'h45, 8'h80};
        logic [7:0] e[2] = '{8'b0110_1010, 8'b1001_0101};
        for (int j = 0; j < 2; j++) begin
            bus(1'b1, csf_pkg::OFS_FLAGS_MAIN, {24'h0, v[j]}, d);
            for (int s = 0; s < 8; s++) begin
                @(posedge sys_clk_in);
                cond_sel_in <= 3'(s);
                @(negedge sys_clk_in);
                chk("condition", {7'h0, cond_true_out}, {7'h0, e[j][s]});
            end
        end
    endtask
    initial begin
        {srst_in, op_valid_in, count_zero_in, interrupt_enable_copy_in, avs_read_in, avs_write_in} = 6'h20;
        {op_code_in, opa_in, opb_in, bit_sel_in, cond_sel_in, avs_address_in, avs_writedata_in} = '0;
        {avs_byteenable_in, mismatches, n_checks, cyc} = {4'hf, 96'h0};
        repeat (12) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        @(negedge sys_clk_in);
        chk("reset main", flags_main_out, csf_pkg::FLAGS_MAIN_RST);
        t_arith();
        t_logic();
        sh(csf_pkg::OP_ROT_LEFT_ACC, 8'h80, 8'h01, 1'b1);
        sh(csf_pkg::OP_ROT_LEFT_CIRC, 8'h81, 8'h03, 1'b1);
        sh(csf_pkg::OP_SHIFT_LEFT_AR, 8'h40, 8'h80, 1'b0);
        sh(csf_pkg::OP_ROT_RIGHT_ACC, 8'h01, 8'h80, 1'b1);
        sh(csf_pkg::OP_ROT_RIGHT_CIRC, 8'h02, 8'h01, 1'b0);
        sh(csf_pkg::OP_SHIFT_RIGHT_AR, 8'h81, 8'hc0, 1'b1);
        sh(csf_pkg::OP_SHIFT_RIGHT_LG, 8'h01, 8'h00, 1'b1);
        sp(csf_pkg::OP_BLOCK_SEARCH, 8'h00, 8'h00, 3'h1, 8'h04, 8'h00);
        sp(csf_pkg::OP_BLOCK_MOVE, 8'h00, 8'h00, 3'h0, 8'h04, 8'h04);
        sp(csf_pkg::OP_BLOCK_IO_STEP, 8'h00, 8'h00, 3'h1, 8'h40, 8'h40);
        sp(csf_pkg::OP_BLOCK_IO_STEP, 8'h00, 8'h00, 3'h0, 8'h40, 8'h00);
        sp(csf_pkg::OP_LOAD_VEC_REF, 8'h00, 8'h00, 3'h1, 8'h04, 8'h04);
        sp(csf_pkg::OP_LOAD_VEC_REF, 8'h00, 8'h00, 3'h0, 8'h04, 8'h00);
        sp(csf_pkg::OP_INPUT_PORT_C, 8'h83, 8'h00, 3'h0, 8'hc4, 8'h80);
        sp(csf_pkg::OP_INPUT_PORT_C, 8'h00, 8'h00, 3'h0, 8'hc4, 8'h44);
        sp(csf_pkg::OP_BIT_TEST, 8'h10, 8'h00, 3'h4, 8'h40, 8'h00);
        sp(csf_pkg::OP_BIT_TEST, 8'h10, 8'h00, 3'h3, 8'h40, 8'h40);
        sp(csf_pkg::OP_CMP, 8'h5a, 8'h5a, 3'h0, 8'h40, 8'h40);
        sp(csf_pkg::OP_CMP, 8'h5a, 8'h5b, 3'h0, 8'h40, 8'h00);
        t_bus();
        t_cond();
        tally_and_finish();
    end
endmodule
bind csf_flags csf_flags_assertions u_chk (.*);
